// *** rtl/pwio_port.sv ***
// Parallel word I/O port: registers, handshakes, interrupt requests
//
// Operation
// - Device ready pulse sets input flag; requests input irq if enabled.
// - Host acknowledge of input irq clears input irq enable.
// - Host read of input register pulses input-taken to the device.
// - Bit mode: a line setting its buffer bit requests input irq if input enabled.
// - Writing input register clears bits written one, keeps others.
// - Status write with input enable set also clears input flag.
// - Output register load pulses data-valid so device reads lines.
// - Output-accepted pulse sets output flag; irq if output enabled.
// - Host acknowledge of output irq clears output irq enable.
// - Status write with output enable bit sets output irq enable.
// - Low data-valid fires on low byte or word load, bits 7..0.
// - High data-valid fires on high byte or word load, bits 15..8.
// - Sixteen input lines feed the input register.
// - Sixteen output lines driven from the output register.
// - Initialize output asserted at reset and on software initialize.
// - Input-taken tells the device new data may be presented.
// - Status: out flag 15, out enable 14, in flag 7, in enable 6.
// - Writing one to bit 13 or 5 raises output or input irq.
// - Option picks live lines or buffered register for input reads.
// - Unused bits read zero; writes to them have no effect.
`timescale 1ns/100ps
module pwio_port (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Avalon-MM register slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Host interrupt request and acknowledge
    output logic             in_irq_req_o,
    input  wire logic        in_irq_ack_i,
    output logic             out_irq_req_o,
    input  wire logic        out_irq_ack_i,
    // External device, input path
    input  wire logic [15:0] parallel_input_lines_i,
    input  wire logic        in_ready_i,
    output logic             in_taken_o,
    // External device, output path
    output logic      [15:0] parallel_output_lines_o,
    output logic             out_lo_valid_o,
    output logic             out_hi_valid_o,
    input  wire logic [1:0]  out_accept_i,
    // External device, initialize
    output logic             init_o
);

    // ==========================================================
    // Bus slave and decoded access
    pwio_reg_if reg_bus ();

    pwio_avs u_avs (
        .clk_i             (clk_i),
        .nrst_i            (nrst_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .bus               (reg_bus)
    );

    // ==========================================================
    // Incoming strobes, synchronised and edge detected
    wire logic       rdy_pulse;
    wire logic [1:0] acc_pulses;
    wire logic       acc_pulse;

    pwio_sync_edge u_rdy (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .strobe_i (in_ready_i),
        .pulse_o  (rdy_pulse)
    );

    // Two accepted lines, either one completes the output handshake
    for (genvar g = 0; g < 2; g++) begin : g_acc
        pwio_sync_edge u_acc (
            .clk_i    (clk_i),
            .nrst_i   (nrst_i),
            .strobe_i (out_accept_i[g]),
            .pulse_o  (acc_pulses[g])
        );
    end
    assign acc_pulse = |acc_pulses;

    // ==========================================================
    // Registers
    logic [15:0] outreg_ff;
    logic [15:0] inbuf_ff;
    logic [15:0] in_prev_ff;
    logic        out_flag_ff;
    logic        out_ie_ff;
    logic        in_flag_ff;
    logic        in_ie_ff;
    logic        cfg_buf_ff;
    logic        cfg_bitirq_ff;
    logic        in_req_ff;
    logic        out_req_ff;
    logic        lo_valid_ff;
    logic        hi_valid_ff;
    logic        taken_ff;
    logic        init_ff;

    // ==========================================================
    // Write and read decode
    wire logic [15:0] wd;
    wire logic wr_lo;
    wire logic wr_hi;
    wire logic st_wr_lo;
    wire logic st_wr_hi;
    wire logic in_wr_lo;
    wire logic in_wr_hi;
    wire logic out_wr_lo;
    wire logic out_wr_hi;
    wire logic cfg_wr_lo;
    wire logic in_rd;
    wire logic sw_init;

    assign wd        = reg_bus.wdata;
    assign wr_lo     = reg_bus.wr & reg_bus.be[0];
    assign wr_hi     = reg_bus.wr & reg_bus.be[1];
    assign st_wr_lo  = wr_lo & (reg_bus.addr == pwio_pkg::ADDR_STATUS);
    assign st_wr_hi  = wr_hi & (reg_bus.addr == pwio_pkg::ADDR_STATUS);
    assign in_wr_lo  = wr_lo & (reg_bus.addr == pwio_pkg::ADDR_INPUT);
    assign in_wr_hi  = wr_hi & (reg_bus.addr == pwio_pkg::ADDR_INPUT);
    assign out_wr_lo = wr_lo & (reg_bus.addr == pwio_pkg::ADDR_OUTPUT);
    assign out_wr_hi = wr_hi & (reg_bus.addr == pwio_pkg::ADDR_OUTPUT);
    assign cfg_wr_lo = wr_lo & (reg_bus.addr == pwio_pkg::ADDR_CONFIG);
    assign in_rd     = reg_bus.rd & (reg_bus.addr == pwio_pkg::ADDR_INPUT);
    assign sw_init   = cfg_wr_lo & wd[pwio_pkg::CFG_INIT];

    // ==========================================================
    // Input buffer: lines latch on their rising edge, software
    // clears with ones; a new edge beats a clear in the same cycle
    wire logic [15:0] rise;
    wire logic [15:0] in_clr;
    wire logic [15:0] nxt_inbuf;

    assign rise      = parallel_input_lines_i & ~in_prev_ff;
    assign in_clr    = {in_wr_hi ? wd[15:8] : 8'h00,
                        in_wr_lo ? wd[7:0]  : 8'h00};
    assign nxt_inbuf = (inbuf_ff & ~in_clr) | rise;

    // ==========================================================
    // Input side flags and interrupt request
    wire logic in_ack;
    wire logic in_ev;
    wire logic nxt_in_ie;
    wire logic nxt_in_flag;
    wire logic nxt_in_req;

    assign in_ack      = in_irq_ack_i & in_req_ff;
    assign in_ev       = (rdy_pulse & in_ie_ff)
                       | (cfg_bitirq_ff & in_ie_ff & |rise)
                       | (st_wr_lo & wd[pwio_pkg::ST_IN_MAINT]);
    // A software write of the enable beats a coincident acknowledge
    assign nxt_in_ie   = st_wr_lo ? wd[pwio_pkg::ST_IN_IE]
                                  : (in_ie_ff & ~in_ack);
    assign nxt_in_flag = rdy_pulse
                       | (in_flag_ff &
                          ~(st_wr_lo & wd[pwio_pkg::ST_IN_IE]));
    assign nxt_in_req  = in_ev | (in_req_ff & ~in_irq_ack_i);

    // ==========================================================
    // Output side flags and interrupt request
    wire logic out_ack;
    wire logic out_ev;
    wire logic nxt_out_ie;
    wire logic nxt_out_flag;
    wire logic nxt_out_req;
    wire logic [15:0] nxt_outreg;

    assign out_ack      = out_irq_ack_i & out_req_ff;
    assign out_ev       = (acc_pulse & out_ie_ff)
                        | (st_wr_hi & wd[pwio_pkg::ST_OUT_MAINT]);
    assign nxt_out_ie   = st_wr_hi ? wd[pwio_pkg::ST_OUT_IE]
                                   : (out_ie_ff & ~out_ack);
    // Loading new data retires the old flag; an accept still wins
    assign nxt_out_flag = acc_pulse
                        | (out_flag_ff & ~(out_wr_lo | out_wr_hi));
    assign nxt_out_req  = out_ev | (out_req_ff & ~out_irq_ack_i);
    assign nxt_outreg   = {out_wr_hi ? wd[15:8] : outreg_ff[15:8],
                           out_wr_lo ? wd[7:0]  : outreg_ff[7:0]};

    // ==========================================================
    // Data registers and configuration
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            outreg_ff     <= pwio_pkg::OUTREG_RST;
            inbuf_ff      <= pwio_pkg::INBUF_RST;
            in_prev_ff    <= 16'h0000;
            cfg_buf_ff    <= pwio_pkg::CFG_RST;
            cfg_bitirq_ff <= pwio_pkg::CFG_RST;
        end else begin
            outreg_ff  <= nxt_outreg;
            inbuf_ff   <= nxt_inbuf;
            in_prev_ff <= parallel_input_lines_i;
            if (cfg_wr_lo) begin
                cfg_buf_ff    <= wd[pwio_pkg::CFG_BUFFERED];
                cfg_bitirq_ff <= wd[pwio_pkg::CFG_BITIRQ];
            end
        end
    end

    // ==========================================================
    // Status flags, enables and interrupt requests
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_ie_ff    <= 1'b0;
            in_flag_ff  <= 1'b0;
            in_req_ff   <= 1'b0;
            out_ie_ff   <= 1'b0;
            out_flag_ff <= 1'b0;
            out_req_ff  <= 1'b0;
        end else begin
            in_ie_ff    <= nxt_in_ie;
            in_flag_ff  <= nxt_in_flag;
            in_req_ff   <= nxt_in_req;
            out_ie_ff   <= nxt_out_ie;
            out_flag_ff <= nxt_out_flag;
            out_req_ff  <= nxt_out_req;
        end
    end

    // ==========================================================
    // Outgoing one-cycle strobes; initialize also stands in reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lo_valid_ff <= 1'b0;
            hi_valid_ff <= 1'b0;
            taken_ff    <= 1'b0;
            init_ff     <= 1'b1;
        end else begin
            lo_valid_ff <= out_wr_lo;
            hi_valid_ff <= out_wr_hi;
            taken_ff    <= in_rd;
            init_ff     <= sw_init;
        end
    end

    // ==========================================================
    // Read values; unused bits are driven to zero
    logic [15:0] status_rd;
    logic [15:0] cfg_rd;
    wire  logic [15:0] input_rd;

    always_comb begin
        status_rd = 16'h0000;
        status_rd[pwio_pkg::ST_OUT_FLAG] = out_flag_ff;
        status_rd[pwio_pkg::ST_OUT_IE]   = out_ie_ff;
        status_rd[pwio_pkg::ST_IN_FLAG]  = in_flag_ff;
        status_rd[pwio_pkg::ST_IN_IE]    = in_ie_ff;
        cfg_rd = 16'h0000;
        cfg_rd[pwio_pkg::CFG_BUFFERED] = cfg_buf_ff;
        cfg_rd[pwio_pkg::CFG_BITIRQ]   = cfg_bitirq_ff;
    end

    assign input_rd = cfg_buf_ff ? inbuf_ff
                                 : parallel_input_lines_i;
    assign reg_bus.rdata =
        (reg_bus.addr == pwio_pkg::ADDR_STATUS) ? status_rd :
        (reg_bus.addr == pwio_pkg::ADDR_INPUT)  ? input_rd  :
        (reg_bus.addr == pwio_pkg::ADDR_OUTPUT) ? outreg_ff :
        (reg_bus.addr == pwio_pkg::ADDR_CONFIG) ? cfg_rd    :
        16'h0000;

    // ==========================================================
    // Outputs
    assign parallel_output_lines_o = outreg_ff;
    assign out_lo_valid_o = lo_valid_ff;
    assign out_hi_valid_o = hi_valid_ff;
    assign in_taken_o     = taken_ff;
    assign init_o         = init_ff;
    assign in_irq_req_o   = in_req_ff;
    assign out_irq_req_o  = out_req_ff;

    // ==========================================================
    // Checks
    property p_in_ready;
        @(posedge clk_i) disable iff (!nrst_i)
            rdy_pulse |=> in_flag_ff && (in_irq_req_o || !$past(in_ie_ff));
    endproperty
    a_in_ready: assert property (p_in_ready)
        else $error("ready did not set flag or request");

    property p_in_ack;
        @(posedge clk_i) disable iff (!nrst_i)
            in_ack && !st_wr_lo |=> !in_ie_ff;
    endproperty
    a_in_ack: assert property (p_in_ack)
        else $error("input enable survived acknowledge");

    property p_taken;
        @(posedge clk_i) disable iff (!nrst_i)
            in_rd |=> in_taken_o ##1 !in_taken_o;
    endproperty
    a_taken: assert property (p_taken)
        else $error("input-taken not a single pulse after read");

    property p_bit_irq;
        @(posedge clk_i) disable iff (!nrst_i)
            cfg_bitirq_ff && in_ie_ff && (|rise) |=> in_irq_req_o;
    endproperty
    a_bit_irq: assert property (p_bit_irq)
        else $error("bit interrupt not requested");

    property p_inbuf_clr;
        @(posedge clk_i) disable iff (!nrst_i)
            in_wr_lo && wd[7:0] == 8'hff && rise[7:0] == 8'h00
            |=> inbuf_ff[7:0] == 8'h00;
    endproperty
    a_inbuf_clr: assert property (p_inbuf_clr)
        else $error("buffered input low byte not cleared");

    property p_en_pattern;
        @(posedge clk_i) disable iff (!nrst_i)
            st_wr_lo && wd[pwio_pkg::ST_IN_IE] && !rdy_pulse
            |=> in_ie_ff && !in_flag_ff;
    endproperty
    a_en_pattern: assert property (p_en_pattern)
        else $error("enable pattern did not set enable and clear flag");

    property p_lo_valid;
        @(posedge clk_i) disable iff (!nrst_i)
            out_wr_lo |=> out_lo_valid_o &&
            parallel_output_lines_o[7:0] == $past(wd[7:0]);
    endproperty
    a_lo_valid: assert property (p_lo_valid)
        else $error("low data-valid or low byte wrong");

    property p_hi_valid;
        @(posedge clk_i) disable iff (!nrst_i)
            out_wr_hi |=> out_hi_valid_o &&
            parallel_output_lines_o[15:8] == $past(wd[15:8]);
    endproperty
    a_hi_valid: assert property (p_hi_valid)
        else $error("high data-valid or high byte wrong");

    property p_out_acc;
        @(posedge clk_i) disable iff (!nrst_i)
            acc_pulse && out_ie_ff |=> out_flag_ff && out_irq_req_o;
    endproperty
    a_out_acc: assert property (p_out_acc)
        else $error("accept did not set flag and request");

    property p_out_ack;
        @(posedge clk_i) disable iff (!nrst_i)
            out_ack && !st_wr_hi |=> !out_ie_ff;
    endproperty
    a_out_ack: assert property (p_out_ack)
        else $error("output enable survived acknowledge");

    property p_maint;
        @(posedge clk_i) disable iff (!nrst_i)
            st_wr_hi && wd[pwio_pkg::ST_OUT_MAINT] |=> out_irq_req_o;
    endproperty
    a_maint: assert property (p_maint)
        else $error("maintenance bit gave no output request");

    property p_sel;
        @(posedge clk_i) disable iff (!nrst_i)
            in_rd && cfg_buf_ff |=> avs_readdata_o[15:0] == $past(inbuf_ff);
    endproperty
    a_sel: assert property (p_sel)
        else $error("buffered read returned wrong value");

    property p_init;
        @(posedge clk_i) disable iff (!nrst_i)
            sw_init |=> init_o ##1 !init_o;
    endproperty
    a_init: assert property (p_init)
        else $error("software initialize not a single pulse");

endmodule : pwio_port

// *** shared/pwio_pkg.sv ***
// Shared constants for the parallel word I/O port
package pwio_pkg;

    // ==========================================================
    // Widths
    localparam int DW          = 16;
    localparam int AW          = 4;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Register byte offsets on the slave bus
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_INPUT  = 4'h4;
    localparam logic [3:0] ADDR_OUTPUT = 4'h8;
    localparam logic [3:0] ADDR_CONFIG = 4'hc;

    // ==========================================================
    // Status register fields
    localparam int ST_OUT_FLAG  = 15;
    localparam int ST_OUT_IE    = 14;
    localparam int ST_OUT_MAINT = 13;
    localparam int ST_IN_FLAG   = 7;
    localparam int ST_IN_IE     = 6;
    localparam int ST_IN_MAINT  = 5;

    // ==========================================================
    // Configuration register fields
    localparam int CFG_BUFFERED = 0;
    localparam int CFG_BITIRQ   = 1;
    localparam int CFG_INIT     = 2;

    // ==========================================================
    // Reset values
    localparam logic [15:0] OUTREG_RST = 16'h0000;
    localparam logic [15:0] INBUF_RST  = 16'h0000;
    localparam logic        CFG_RST    = 1'b0;

endpackage : pwio_pkg

// *** shared/pwio_reg_if.sv ***
// Decoded register access between bus slave and port core
`timescale 1ns/100ps
interface pwio_reg_if;
    logic        wr;     // One-cycle write pulse
    logic        rd;     // One-cycle read pulse
    logic [3:0]  addr;   // Aligned byte offset
    logic [1:0]  be;     // Low and high byte enables
    logic [15:0] wdata;
    logic [15:0] rdata;  // Combinational read value

    modport slave (output wr, rd, addr, be, wdata, input rdata);
    modport core  (input wr, rd, addr, be, wdata, output rdata);
endinterface : pwio_reg_if

// *** rtl/pwio_sync_edge.sv ***
// Strobe synchroniser with rising-edge pulse detector
`timescale 1ns/100ps
module pwio_sync_edge #(
    parameter int STAGES = pwio_pkg::SYNC_STAGES
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // Strobe in, pulse out
    input  wire logic strobe_i,
    output logic      pulse_o
);

    // ==========================================================
    // Elaboration check
    if (STAGES < 2) begin : g_chk
        $error("pwio_sync_edge needs at least two stages");
    end

    logic [STAGES-1:0] sync_ff;
    logic              last_ff;

    // ==========================================================
    // Synchroniser chain; only the last stage feeds the detector
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_ff <= '0;
            last_ff <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[STAGES-2:0], strobe_i};
            last_ff <= sync_ff[STAGES-1];
        end
    end

    // One pulse per rising edge, however long the strobe stays high
    assign pulse_o = sync_ff[STAGES-1] & ~last_ff;

    property p_pulse_one;
        @(posedge clk_i) disable iff (!nrst_i)
            pulse_o |=> !pulse_o;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("strobe pulse longer than one cycle");

endmodule : pwio_sync_edge

// *** rtl/pwio_avs.sv ***
// Avalon-MM slave front end that turns accesses into pulses
`timescale 1ns/100ps
module pwio_avs (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Decoded access toward the core
    pwio_reg_if.slave        bus
);

    logic        wait_ff;
    logic [31:0] rdata_ff;
    wire  logic  take;
    wire  logic  aligned;
    wire  logic [31:0] nxt_rdata;

    // ==========================================================
    // Decode: each access is taken once, on the cycle its
    // waitrequest is still high; misaligned offsets are unmapped
    assign take      = (avs_read_i | avs_write_i) & wait_ff;
    assign aligned   = (avs_address_i[1:0] == 2'h0);
    assign bus.wr    = take & avs_write_i & aligned;
    assign bus.rd    = take & avs_read_i & aligned;
    assign bus.addr  = avs_address_i;
    assign bus.be    = avs_byteenable_i[1:0];
    assign bus.wdata = avs_writedata_i[15:0];
    assign nxt_rdata = (take & avs_read_i) ?
                       {16'h0000, aligned ? bus.rdata : 16'h0000} :
                       rdata_ff;

    // ==========================================================
    // Answer one cycle after the request; waitrequest then rises
    // again so a held request is never taken twice
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff  <= ~take;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o    = rdata_ff;

    property p_wait_one;
        @(posedge clk_i) disable iff (!nrst_i)
            take |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest not low for exactly one cycle");

endmodule : pwio_avs

// *** test/pwio_ext_dev.sv ***
// Behavioural model of the external device on the parallel port
`timescale 1ns/100ps
module pwio_ext_dev #(
    parameter int DLY = 3
) (
    // Clock and bench command
    input  wire logic        clk_i,
    input  wire logic        send_i,
    input  wire logic [15:0] word_i,
    // Port side
    output logic      [15:0] lines_o,
    output logic             ready_o,
    input  wire logic        lo_v_i,
    input  wire logic        hi_v_i,
    input  wire logic [15:0] out_lines_i,
    output logic      [1:0]  accept_o,
    output logic      [15:0] seen_o
);
    logic sel = 1'b0;
    initial begin
        lines_o = 16'h0000;
        ready_o = 1'b0;
        accept_o = 2'b00;
        seen_o = 16'h0000;
    end
    // ==========================================================
    // Word first, then a two-cycle ready strobe
    always @(posedge clk_i) begin
        if (send_i) begin
            lines_o <= word_i;
            @(posedge clk_i) ready_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            ready_o <= 1'b0;
        end
    end
    // Read lines on data-valid, answer late on alternating lines
    always @(posedge clk_i) begin
        if (lo_v_i | hi_v_i) begin
            seen_o <= out_lines_i;
            repeat (DLY) @(posedge clk_i);
            accept_o[sel] <= 1'b1;
            repeat (2) @(posedge clk_i);
            accept_o <= 2'b00;
            sel <= ~sel;
        end
    end
endmodule : pwio_ext_dev

// *** test/parallel_word_io_handshake_bench.sv ***
// Self-checking bench for the parallel word I/O port
`timescale 1ns/100ps
module parallel_word_io_handshake_bench;
    localparam logic [3:0] S = pwio_pkg::ADDR_STATUS;
    localparam logic [3:0] I = pwio_pkg::ADDR_INPUT;
    localparam logic [3:0] O = pwio_pkg::ADDR_OUTPUT;
    localparam logic [3:0] C = pwio_pkg::ADDR_CONFIG;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
    logic clk_i = 0, nrst_i = 0, rd = 0, wr = 0, in_ack = 0, out_ack = 0;
    logic [3:0] adr = 0, be = 0;
    logic [31:0] wd = 0, rdat;
    logic wq, iq, oq, tk, lo, hi, ini, rdy, snd = 0;
    logic [15:0] lin, lout, seen, q, w16 = 0;
    logic [1:0] acc;
    int miscompares = 0, n_compared = 0;
    int n_tk = 0, n_lo = 0, n_hi = 0, n_in = 0;
    pwio_port dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .in_irq_req_o(iq), .in_irq_ack_i(in_ack),
        .out_irq_req_o(oq), .out_irq_ack_i(out_ack),
        .parallel_input_lines_i(lin), .in_ready_i(rdy), .in_taken_o(tk),
        .parallel_output_lines_o(lout), .out_lo_valid_o(lo),
        .out_hi_valid_o(hi), .out_accept_i(acc), .init_o(ini));
    pwio_ext_dev dev (.clk_i(clk_i), .send_i(snd), .word_i(w16),
        .lines_o(lin), .ready_o(rdy), .lo_v_i(lo), .hi_v_i(hi),
        .out_lines_i(lout), .accept_o(acc), .seen_o(seen));
    // ==========================================================
    // Clock, and pulse counters sampled at each rising edge
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_tk += tk; n_lo += lo; n_hi += hi; n_in += ini & nrst_i;
    end
    // Hold the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [15:0] d, input logic [1:0] b);
        wr <= w; rd <= ~w; adr <= a; wd <= {16'h0000, d}; be <= {2'b00, b};
        do @(posedge clk_i); while (wq !== 1'b0);
        q = rdat[15:0];
        rd <= 1'b0; wr <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000, 2'b11);
        `CHK(q, e)
    endtask : rchk
    // The caller picks how long to wait, so a check can land before
    // or after the ready strobe reaches the port
    task automatic send(input logic [15:0] d, input int n);
        w16 <= d; snd <= 1'b1; @(posedge clk_i) snd <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask : send
    // One-cycle acknowledge, then let the request drop
    task automatic ack(input logic o);
        if (o) out_ack <= 1'b1; else in_ack <= 1'b1;
        @(posedge clk_i) begin out_ack <= 1'b0; in_ack <= 1'b0; end
        @(posedge clk_i);
    endtask : ack
    task automatic close_out;
        if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    initial begin repeat (3000) @(posedge clk_i); miscompares++; close_out; end
    // ==========================================================
    // Tests
    initial begin
        repeat (8) @(posedge clk_i);
        `CHK(ini, 1'b1)
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rchk(S, 16'h0000);
        bus(1'b1, S, 16'h0040, 2'b11);
        send(16'h1230, 6);
        `CHK(iq, 1'b1)
        rchk(S, 16'h00c0);
        ack(1'b0);
        `CHK(iq, 1'b0)
        rchk(S, 16'h0080);
        rchk(I, 16'h1230);
        `CHK(n_tk, 1)
        bus(1'b1, S, 16'h4040, 2'b11);
        rchk(S, 16'h4040);
        bus(1'b1, O, 16'ha5c3, 2'b11);
        `CHK(lout, 16'ha5c3)
        `CHK({n_lo, n_hi}, {32'd1, 32'd1})
        repeat (10) @(posedge clk_i);
        `CHK(oq, 1'b1)
        `CHK(seen, 16'ha5c3)
        ack(1'b1);
        rchk(S, 16'h8040);
        bus(1'b1, O, 16'h005a, 2'b01);
        `CHK({n_lo, n_hi, lout}, {32'd2, 32'd1, 16'ha55a})
        repeat (10) @(posedge clk_i);
        rchk(S, 16'h8040);
        bus(1'b1, S, 16'h0020, 2'b01);
        @(posedge clk_i);
        `CHK(iq, 1'b1)
        ack(1'b0);
        // Output maintenance bit raises the output request by itself
        bus(1'b1, S, 16'h2000, 2'b10);
        `CHK(oq, 1'b1)
        ack(1'b1);
        bus(1'b1, C, 16'h0003, 2'b11);
        bus(1'b1, I, 16'hffff, 2'b11);
        bus(1'b1, S, 16'h0040, 2'b11);
        // Look before the ready strobe lands: only a line can have
        // raised the request at this point
        send(16'h0005, 2);
        `CHK(iq, 1'b1)
        ack(1'b0);
        rchk(I, 16'h0005);
        bus(1'b1, I, 16'h0001, 2'b11);
        rchk(I, 16'h0004);
        rchk(4'h2, 16'h0000);
        bus(1'b1, C, 16'h0004, 2'b11);
        `CHK(n_in, 2)
        close_out;
    end
endmodule : parallel_word_io_handshake_bench
